// ### core/csb_channel.sv
`timescale 1ns/100ps
// Contract
// - Continuous mode: tx irq on buffer-to-shifter move
// - Single mode: no tx irq, rx irq at end
// - Rx irq when received byte sits in buffer
// - Single mode: tx write while busy discarded
// - Powered down: clock pin hi-Z or idle level
// - Clock pin follows polarity/select rewrites at once
// - Powered down: data pin low or tx bit
// - Data pin follows enable/order/phase rewrites at once
// - Compare registers: 8-bit, whole byte, reset 00
// - Mode registers: byte/bit access, reset 00
// - Count clock = main / (2^(k+1) * N)
// - Compare 00 selects divide by 256
// - Sticky overrun flag, software reads after DMA
// - Phase 1: busy clears half clock after rx irq
// - Rx-only single: busy read starts nothing
module csb_channel (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite register port
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [11:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // Serial pins
    input wire logic serial_clock_pin_i,
    output logic serial_clock_pin_o,
    output logic serial_clock_pin_oe_n,
    input wire logic serial_data_in_pin,
    output logic serial_data_out_pin,
    // Event pulses
    output logic tx_irq,
    output logic rx_complete_irq
);
    csb_pkg::csb_state_s state_reg;
    csb_pkg::csb_state_s state_next;
    logic [2:0][12:0] lim;
    logic ext_edge;
    logic ch_tick;
    logic do_wr;
    logic do_rd;
    logic wr_ok;
    logic busy;
    logic pwr;
    logic cont;
    logic ext;
    logic dir;
    logic dap;
    logic [1:0] sel;
    logic [7:0] rx_nxt;
    logic [7:0] rd_val;
    logic di_cur;

    always_comb begin
        state_next = state_reg;
        ext_edge = 1'b0;
        do_rd = 1'b0;
        wr_ok = 1'b0;
        rd_val = csb_pkg::REG_RESET;
        rx_nxt = state_reg.rxsh;
        state_next.tx_irq = 1'b0;
        state_next.rx_irq = 1'b0;
        pwr = state_reg.ctl0[csb_pkg::POWER_BIT];
        cont = state_reg.ctl0[csb_pkg::MODE_BIT];
        dir = state_reg.ctl0[csb_pkg::ORDER_BIT];
        dap = state_reg.ctl1[csb_pkg::PHASE_BIT];
        ext = state_reg.ctl1[2:0] == csb_pkg::CKS_EXTERNAL;
        busy = state_reg.st != csb_pkg::ST_IDLE;
        // Pin synchronisers
        state_next.ck_sync = {state_reg.ck_sync[1:0], serial_clock_pin_i};
        state_next.di_sync = {state_reg.di_sync[1:0], serial_data_in_pin};
        if (state_reg.ck_sync[1] == state_reg.ck_sync[2]
                && state_reg.ck_sync[2] != state_reg.ck_lvl) begin
            state_next.ck_lvl = state_reg.ck_sync[2];
            ext_edge = 1'b1;
        end
        di_cur = (state_reg.di_sync[1] == state_reg.di_sync[2]) ? state_reg.di_sync[2]
            : state_reg.di_lvl;
        state_next.di_lvl = di_cur;
        // Baud generators
        for (int i = 0; i < 3; i++) begin
            lim[i] = ((state_reg.cmp[i] == csb_pkg::REG_RESET) ? csb_pkg::CMP_ZERO_RATIO
                : {5'h00, state_reg.cmp[i]})
                << ({1'b0, state_reg.mode[i][1:0]} + 3'h1);
            state_next.tick[i] = 1'b0;
            if (!state_reg.mode[i][csb_pkg::BGEN_BIT]) begin
                state_next.cnt[i] = 12'h000;
            end else if ({1'b0, state_reg.cnt[i]} == lim[i] - 13'h0001) begin
                state_next.cnt[i] = 12'h000;
                state_next.tick[i] = 1'b1;
            end else begin
                state_next.cnt[i] = state_reg.cnt[i] + 12'h001;
            end
        end
        sel = (state_reg.ctl1[1:0] == 2'h3) ? 2'h2 : state_reg.ctl1[1:0];
        ch_tick = ext ? ext_edge : state_reg.tick[sel];
        // AXI write channels
        if (state_reg.awready && s_axi_awvalid) begin
            state_next.awready = 1'b0;
            state_next.aw_held = 1'b1;
            state_next.waddr = s_axi_awaddr;
        end
        if (state_reg.wready && s_axi_wvalid) begin
            state_next.wready = 1'b0;
            state_next.w_held = 1'b1;
            state_next.wdata = s_axi_wdata[7:0];
            state_next.wstrb0 = s_axi_wstrb[0];
        end
        if (state_reg.bvalid && s_axi_bready) begin
            state_next.bvalid = 1'b0;
            state_next.awready = 1'b1;
            state_next.wready = 1'b1;
        end
        do_wr = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid;
        if (do_wr) begin
            state_next.aw_held = 1'b0;
            state_next.w_held = 1'b0;
            state_next.bvalid = 1'b1;
            state_next.bresp = csb_pkg::RESP_OKAY;
            wr_ok = state_reg.wstrb0;
            unique case (state_reg.waddr)
                csb_pkg::ADDR_CTL0: begin
                    if (wr_ok) begin
                        state_next.ctl0 = state_reg.wdata & csb_pkg::CTL0_MASK;
                    end
                end
                csb_pkg::ADDR_CTL1: begin
                    if (wr_ok) begin
                        state_next.ctl1 = state_reg.wdata & csb_pkg::CTL1_MASK;
                    end
                end
                csb_pkg::ADDR_CTL2: begin
                    if (wr_ok) begin
                        state_next.ctl2 = state_reg.wdata & csb_pkg::CTL2_MASK;
                    end
                end
                csb_pkg::ADDR_STATUS: begin
                    if (wr_ok && state_reg.wdata[csb_pkg::OVR_BIT]) begin
                        state_next.overrun = 1'b0;
                    end
                end
                csb_pkg::ADDR_TX: begin
                    if (wr_ok && !(pwr && busy && !cont)
                            && !(pwr && cont && state_reg.tx_pend)) begin
                        state_next.tx_buf = state_reg.wdata;
                        state_next.tx_pend = pwr && state_reg.ctl0[csb_pkg::TX_EN_BIT];
                    end
                end
                csb_pkg::ADDR_RX: begin
                end
                csb_pkg::ADDR_MODE_ONE, csb_pkg::ADDR_MODE_TWO, csb_pkg::ADDR_MODE_THREE: begin
                    if (wr_ok) begin
                        state_next.mode[state_reg.waddr[5:4] - 2'h2 + state_reg.waddr[3:2]]
                            = state_reg.wdata & csb_pkg::MODE_MASK;
                    end
                end
                csb_pkg::ADDR_CMP_ONE, csb_pkg::ADDR_CMP_TWO, csb_pkg::ADDR_CMP_THREE: begin
                    if (wr_ok) begin
                        state_next.cmp[state_reg.waddr[5:4]] = state_reg.wdata;
                    end
                end
                default: begin
                    state_next.bresp = csb_pkg::RESP_SLVERR;
                end
            endcase
        end
        // AXI read channels
        if (state_reg.rvalid && s_axi_rready) begin
            state_next.rvalid = 1'b0;
            state_next.arready = 1'b1;
        end
        if (state_reg.arready && s_axi_arvalid) begin
            state_next.arready = 1'b0;
            state_next.rvalid = 1'b1;
            state_next.rresp = csb_pkg::RESP_OKAY;
            do_rd = 1'b1;
            unique case (s_axi_araddr)
                csb_pkg::ADDR_CTL0: rd_val = state_reg.ctl0;
                csb_pkg::ADDR_CTL1: rd_val = state_reg.ctl1;
                csb_pkg::ADDR_CTL2: rd_val = state_reg.ctl2;
                csb_pkg::ADDR_STATUS: begin
                    rd_val[csb_pkg::BUSY_BIT] = busy;
                    rd_val[csb_pkg::FULL_BIT] = state_reg.rx_full;
                    rd_val[csb_pkg::OVR_BIT] = state_reg.overrun;
                end
                csb_pkg::ADDR_TX: rd_val = state_reg.tx_buf;
                csb_pkg::ADDR_RX: begin
                    rd_val = state_reg.rx_buf;
                    state_next.rx_full = 1'b0;
                    if (pwr && !busy && state_reg.ctl0[csb_pkg::RX_EN_BIT]
                            && !state_reg.ctl0[csb_pkg::TX_EN_BIT]) begin
                        state_next.rx_go = 1'b1;
                    end
                end
                csb_pkg::ADDR_MODE_ONE: rd_val = state_reg.mode[0];
                csb_pkg::ADDR_MODE_TWO: rd_val = state_reg.mode[1];
                csb_pkg::ADDR_MODE_THREE: rd_val = state_reg.mode[2];
                csb_pkg::ADDR_CMP_ONE: rd_val = state_reg.cmp[0];
                csb_pkg::ADDR_CMP_TWO: rd_val = state_reg.cmp[1];
                csb_pkg::ADDR_CMP_THREE: rd_val = state_reg.cmp[2];
                default: state_next.rresp = csb_pkg::RESP_SLVERR;
            endcase
            state_next.rdata = {24'h000000, rd_val};
        end
        // Transfer engine
        unique case (state_reg.st)
            csb_pkg::ST_IDLE: begin
                state_next.sck = !state_reg.ctl1[csb_pkg::POL_BIT];
                if (pwr && (state_reg.tx_pend || state_reg.rx_go)) begin
                    state_next.st = csb_pkg::ST_SHIFT;
                    state_next.half = 5'h00;
                    state_next.rx_go = 1'b0;
                    state_next.tx_pend = 1'b0;
                    state_next.tx_irq = cont && state_reg.tx_pend;
                    state_next.sh = state_reg.tx_pend ? state_reg.tx_buf : 8'h00;
                    if (!dap) begin
                        state_next.sdo = dir ? state_next.sh[0] : state_next.sh[7];
                        state_next.sh = dir ? {1'b0, state_next.sh[7:1]}
                            : {state_next.sh[6:0], 1'b0};
                    end
                end
            end
            csb_pkg::ST_SHIFT: begin
                if (ch_tick) begin
                    state_next.sck = !state_reg.sck;
                    state_next.half = state_reg.half + 5'h01;
                    if (state_reg.half[0] == dap) begin
                        rx_nxt = dir ? {di_cur, state_reg.rxsh[7:1]}
                            : {state_reg.rxsh[6:0], di_cur};
                        state_next.rxsh = rx_nxt;
                    end else if (state_reg.half != csb_pkg::LAST_HALF) begin
                        state_next.sdo = dir ? state_reg.sh[0] : state_reg.sh[7];
                        state_next.sh = dir ? {1'b0, state_reg.sh[7:1]}
                            : {state_reg.sh[6:0], 1'b0};
                    end
                    if (state_reg.half == csb_pkg::LAST_HALF) begin
                        if (state_reg.ctl0[csb_pkg::RX_EN_BIT]) begin
                            state_next.rx_buf = rx_nxt;
                            state_next.rx_full = 1'b1;
                            if (state_reg.rx_full) begin
                                state_next.overrun = 1'b1;
                            end
                        end
                        state_next.rx_irq = state_reg.ctl0[csb_pkg::RX_EN_BIT]
                            || !cont;
                        state_next.rx_go = cont && state_reg.ctl0[csb_pkg::RX_EN_BIT]
                            && !state_reg.ctl0[csb_pkg::TX_EN_BIT];
                        state_next.st = dap ? csb_pkg::ST_TAIL : csb_pkg::ST_IDLE;
                    end
                end
            end
            csb_pkg::ST_TAIL: begin
                if (ch_tick) begin
                    state_next.st = csb_pkg::ST_IDLE;
                end
            end
            default: state_next.st = csb_pkg::ST_IDLE;
        endcase
        // Pin levels, taken from the next register values
        state_next.sck_oe_n = state_next.ctl1[2:0] == csb_pkg::CKS_EXTERNAL;
        if (!state_next.ctl0[csb_pkg::POWER_BIT]) begin
            state_next.st = csb_pkg::ST_IDLE;
            state_next.tx_pend = 1'b0;
            state_next.rx_go = 1'b0;
            state_next.sck = !state_next.ctl1[csb_pkg::POL_BIT];
            if (!state_next.ctl0[csb_pkg::TX_EN_BIT] || !state_next.ctl1[csb_pkg::PHASE_BIT]) begin
                state_next.sdo = 1'b0;
            end else begin
                state_next.sdo = state_next.ctl0[csb_pkg::ORDER_BIT] ? state_next.tx_buf[0]
                    : state_next.tx_buf[7];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= '0;
            state_reg.awready <= 1'b1;
            state_reg.wready <= 1'b1;
            state_reg.arready <= 1'b1;
            state_reg.sck <= 1'b1;
            state_reg.ck_sync <= 3'h7;
            state_reg.ck_lvl <= 1'b1;
            state_reg.st <= csb_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    assign s_axi_awready = state_reg.awready;
    assign s_axi_wready = state_reg.wready;
    assign s_axi_bvalid = state_reg.bvalid;
    assign s_axi_bresp = state_reg.bresp;
    assign s_axi_arready = state_reg.arready;
    assign s_axi_rvalid = state_reg.rvalid;
    assign s_axi_rdata = state_reg.rdata;
    assign s_axi_rresp = state_reg.rresp;
    assign serial_clock_pin_o = state_reg.sck;
    assign serial_clock_pin_oe_n = state_reg.sck_oe_n;
    assign serial_data_out_pin = state_reg.sdo;
    assign tx_irq = state_reg.tx_irq;
    assign rx_complete_irq = state_reg.rx_irq;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_cont_tx_irq: assert property (state_reg.tx_irq |->
        $past(state_reg.st) == csb_pkg::ST_IDLE && state_reg.st == csb_pkg::ST_SHIFT)
        else $error("tx irq without a load");
    chk_single_no_tx: assert property (state_reg.tx_irq |-> $past(cont))
        else $error("tx irq in single mode");
    chk_rx_irq_buf: assert property ((state_reg.rx_irq && $past(state_reg.ctl0[5]))
        |-> state_reg.rx_full) else $error("rx irq without data");
    chk_busy_discard: assert property ((do_wr && wr_ok && state_reg.waddr ==
        csb_pkg::ADDR_TX && pwr && busy && !cont) |=> $stable(state_reg.tx_buf))
        else $error("busy write accepted");
    chk_sck_release: assert property ((!pwr && ext) |-> state_reg.sck_oe_n)
        else $error("clock pin driven in external select");
    chk_sck_idle: assert property ((!pwr && !ext) |->
        (!state_reg.sck_oe_n && state_reg.sck == !state_reg.ctl1[4]))
        else $error("clock pin idle level wrong");
    chk_sdo_idle: assert property (!pwr |-> state_reg.sdo == (state_reg.ctl0[6]
        && dap && (dir ? state_reg.tx_buf[0] : state_reg.tx_buf[7])))
        else $error("data pin idle level wrong");
    chk_div_period: assert property (state_reg.tick[0] |->
        ($past(state_reg.cnt[0]) == lim[0][11:0] - 12'h001 && state_reg.cnt[0] == 12'h000))
        else $error("divider period wrong");
    chk_ovr_sticky: assert property ((state_reg.overrun && !(do_wr && wr_ok
        && state_reg.waddr == csb_pkg::ADDR_STATUS)) |=> state_reg.overrun)
        else $error("overrun flag lost");
    chk_tail_busy: assert property ((state_reg.rx_irq && dap) |->
        state_reg.st == csb_pkg::ST_TAIL) else $error("busy cleared early");
    chk_rx_no_start: assert property ((do_rd && s_axi_araddr == csb_pkg::ADDR_RX
        && busy && !cont) |=> !state_reg.rx_go) else $error("busy read started transfer");
endmodule : csb_channel

// ### core/csb_pkg.sv
package csb_pkg;
    // Printed prescaler compare offsets are register indices
    localparam logic [31:0] CMP_ONE_IDX = 32'hFFFFF321;
    localparam logic [31:0] CMP_TWO_IDX = 32'hFFFFF325;
    localparam logic [31:0] CMP_THREE_IDX = 32'hFFFFF329;
    localparam logic [11:0] ADDR_CMP_ONE = {CMP_ONE_IDX[9:0], 2'b00};
    localparam logic [11:0] ADDR_CMP_TWO = {CMP_TWO_IDX[9:0], 2'b00};
    localparam logic [11:0] ADDR_CMP_THREE = {CMP_THREE_IDX[9:0], 2'b00};
    localparam logic [11:0] ADDR_CTL0 = 12'h000;
    localparam logic [11:0] ADDR_CTL1 = 12'h004;
    localparam logic [11:0] ADDR_CTL2 = 12'h008;
    localparam logic [11:0] ADDR_STATUS = 12'h00C;
    localparam logic [11:0] ADDR_TX = 12'h010;
    localparam logic [11:0] ADDR_RX = 12'h014;
    localparam logic [11:0] ADDR_MODE_ONE = 12'h020;
    localparam logic [11:0] ADDR_MODE_TWO = 12'h024;
    localparam logic [11:0] ADDR_MODE_THREE = 12'h028;
    // control_reg_zero fields
    localparam int unsigned POWER_BIT = 7;
    localparam int unsigned TX_EN_BIT = 6;
    localparam int unsigned RX_EN_BIT = 5;
    localparam int unsigned ORDER_BIT = 4;
    localparam int unsigned MODE_BIT = 1;
    localparam logic [7:0] CTL0_MASK = 8'hF2;
    // control_reg_one fields
    localparam int unsigned POL_BIT = 4;
    localparam int unsigned PHASE_BIT = 3;
    localparam logic [2:0] CKS_EXTERNAL = 3'h7;
    localparam logic [7:0] CTL1_MASK = 8'h1F;
    localparam logic [7:0] CTL2_MASK = 8'h0F;
    // channel_status_reg fields
    localparam int unsigned BUSY_BIT = 7;
    localparam int unsigned FULL_BIT = 1;
    localparam int unsigned OVR_BIT = 0;
    // prescaler_mode_reg fields
    localparam int unsigned BGEN_BIT = 4;
    localparam logic [7:0] MODE_MASK = 8'h13;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [12:0] CMP_ZERO_RATIO = 13'h0100;
    localparam logic [4:0] LAST_HALF = 5'h0F;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_TAIL} csb_phase_e;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic aw_held;
        logic w_held;
        logic [11:0] waddr;
        logic [7:0] wdata;
        logic wstrb0;
        logic [7:0] ctl0;
        logic [7:0] ctl1;
        logic [7:0] ctl2;
        logic [7:0] tx_buf;
        logic [7:0] rx_buf;
        logic rx_full;
        logic tx_pend;
        logic rx_go;
        logic overrun;
        logic [2:0][7:0] cmp;
        logic [2:0][7:0] mode;
        logic [2:0][11:0] cnt;
        logic [2:0] tick;
        csb_phase_e st;
        logic [4:0] half;
        logic [7:0] sh;
        logic [7:0] rxsh;
        logic sck;
        logic sck_oe_n;
        logic sdo;
        logic tx_irq;
        logic rx_irq;
        logic [2:0] ck_sync;
        logic [2:0] di_sync;
        logic ck_lvl;
        logic di_lvl;
    } csb_state_s;
endpackage : csb_pkg

// ### dv/csb_channel_tb.sv
`timescale 1ns/100ps
module csb_channel_tb;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, sck_i, sck_o, oe_n, sdi, sdo;
    logic tx_irq, rx_irq, peer_en, sck_prev, take_lvl;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd_data;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rd_resp;
    logic [7:0] reply, got;
    int n_mismatch = 0, check_count = 0, n_tx = 0, n_rx = 0, hcnt = 0, hlen = 0;

    // Pull-up on the clock wire while released
    assign sck_i = oe_n ? 1'b1 : sck_o;

    csb_channel u_csb_channel (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .serial_clock_pin_i(sck_i),
        .serial_clock_pin_o(sck_o), .serial_clock_pin_oe_n(oe_n),
        .serial_data_in_pin(sdi), .serial_data_out_pin(sdo),
        .tx_irq(tx_irq), .rx_complete_irq(rx_irq));
    csb_peer u_csb_peer (.sck(sck_i), .sdo(sdo), .sdi(sdi), .en(peer_en),
        .take_lvl(take_lvl), .reply(reply), .got(got));

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    // Event counts and clock half period in cycles
    always @(posedge aclk) begin
        n_tx <= n_tx + int'(tx_irq === 1'b1);
        n_rx <= n_rx + int'(rx_irq === 1'b1);
        sck_prev <= sck_o;
        if (sck_o !== sck_prev) begin
            hlen <= hcnt;
            hcnt <= 1;
        end else begin
            hcnt <= hcnt + 1;
        end
    end

    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %h expected %h", $time, m, g, e);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge aclk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a);
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rd_data = rdata;
        rd_resp = rresp;
        rready <= 1'b0;
    endtask : rd

    task automatic settle;
        repeat (2) @(posedge aclk);
        #1;
    endtask : settle

    task automatic wait_rx(input int n);
        while (n_rx < n) @(posedge aclk);
    endtask : wait_rx

    task automatic conclude;
        if (n_mismatch == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : conclude

    task automatic t_regs;
        logic [11:0] ca [3];
        logic [11:0] ma [3];
        ca = '{csb_pkg::ADDR_CMP_ONE, csb_pkg::ADDR_CMP_TWO, csb_pkg::ADDR_CMP_THREE};
        ma = '{csb_pkg::ADDR_MODE_ONE, csb_pkg::ADDR_MODE_TWO, csb_pkg::ADDR_MODE_THREE};
        for (int i = 0; i < 3; i++) begin
            rd(ca[i]);
            chk(rd_data, 32'h0, "compare reset");
            rd(ma[i]);
            chk(rd_data, 32'h0, "mode reset");
            wr(ca[i], 32'hFFFFFF5A);
            rd(ca[i]);
            chk(rd_data, 32'h5A, "compare byte");
            wr(ma[i], 32'h13);
            rd(ma[i]);
            chk(rd_data, 32'h13, "mode byte");
            wr(ma[i], 32'h0);
        end
        rd(12'h018);
        chk({30'h0, rd_resp}, {30'h0, csb_pkg::RESP_SLVERR}, "unmapped");
    endtask : t_regs

    task automatic t_idle;
        logic [2:0] cks;
        for (int p = 0; p < 2; p++) begin
            for (int c = 0; c < 2; c++) begin
                cks = c ? csb_pkg::CKS_EXTERNAL : 3'h0;
                wr(csb_pkg::ADDR_CTL1, {27'h0, p[0], 1'b0, cks});
                settle;
                chk({31'h0, oe_n}, {31'h0, c[0]}, "clock release");
                if (c == 0) chk({31'h0, sck_o}, {31'h0, ~p[0]}, "clock idle");
            end
        end
        wr(csb_pkg::ADDR_TX, 32'h80);
        for (int i = 0; i < 4; i++) begin
            wr(csb_pkg::ADDR_CTL0, (i ? 32'h40 : 32'h0) | (i == 3 ? 32'h10 : 32'h0));
            wr(csb_pkg::ADDR_CTL1, i > 1 ? 32'h08 : 32'h0);
            settle;
            chk({31'h0, sdo}, {31'h0, i == 2}, "data idle");
        end
    endtask : t_idle

    task automatic t_single;
        int r0, t0;
        wr(csb_pkg::ADDR_CMP_ONE, 32'h02);
        wr(csb_pkg::ADDR_MODE_ONE, 32'h10);
        wr(csb_pkg::ADDR_CTL1, 32'h0);
        reply <= 8'h3C;
        peer_en <= 1'b1;
        r0 = n_rx;
        t0 = n_tx;
        wr(csb_pkg::ADDR_CTL0, 32'hE0);
        wr(csb_pkg::ADDR_TX, 32'hC5);
        wr(csb_pkg::ADDR_TX, 32'h11);
        wait_rx(r0 + 1);
        repeat (300) @(posedge aclk);
        chk(n_rx - r0, 32'h1, "rx events");
        chk(n_tx - t0, 32'h0, "tx events");
        chk({24'h0, got}, 32'hC5, "sent byte");
        chk(hlen, 32'h4, "half period");
        rd(csb_pkg::ADDR_RX);
        chk(rd_data, 32'h3C, "received byte");
        wr(csb_pkg::ADDR_CTL0, 32'h0);
        wr(csb_pkg::ADDR_CTL0, 32'hA0);
        reply <= 8'hA5;
        r0 = n_rx;
        rd(csb_pkg::ADDR_RX);
        rd(csb_pkg::ADDR_RX);
        wait_rx(r0 + 1);
        repeat (300) @(posedge aclk);
        chk(n_rx - r0, 32'h1, "rx-only events");
        rd(csb_pkg::ADDR_RX);
        chk(rd_data, 32'hA5, "rx-only byte");
    endtask : t_single

    task automatic t_cont;
        int r0, t0;
        wr(csb_pkg::ADDR_CTL0, 32'h0);
        wr(csb_pkg::ADDR_MODE_ONE, 32'h0);
        wr(csb_pkg::ADDR_CMP_ONE, 32'h0);
        wr(csb_pkg::ADDR_MODE_ONE, 32'h10);
        wr(csb_pkg::ADDR_CTL1, 32'h08);
        take_lvl <= 1'b1;
        reply <= 8'h96;
        r0 = n_rx;
        t0 = n_tx;
        wr(csb_pkg::ADDR_CTL0, 32'hE2);
        wr(csb_pkg::ADDR_TX, 32'hA1);
        wr(csb_pkg::ADDR_TX, 32'h5E);
        wait_rx(r0 + 2);
        repeat (20) @(posedge aclk);
        chk(n_tx - t0, 32'h2, "tx events");
        chk(hlen, 32'h200, "divide by 256");
        chk({24'h0, got}, 32'h5E, "second byte");
        rd(csb_pkg::ADDR_RX);
        rd(csb_pkg::ADDR_STATUS);
        chk({31'h0, rd_data[csb_pkg::OVR_BIT]}, 32'h1, "overrun kept");
        chk({31'h0, rd_data[csb_pkg::BUSY_BIT]}, 32'h1, "busy in tail");
        repeat (600) @(posedge aclk);
        rd(csb_pkg::ADDR_STATUS);
        chk({31'h0, rd_data[csb_pkg::BUSY_BIT]}, 32'h0, "busy cleared");
    endtask : t_cont

    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, peer_en, take_lvl} = '0;
        awaddr = 12'h0;
        araddr = 12'h0;
        wdata = 32'h0;
        wstrb = 4'hF;
        reply = 8'h00;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs;
        t_idle;
        t_single;
        t_cont;
        conclude;
    end

    initial begin
        repeat (30000) @(posedge aclk);
        n_mismatch++;
        conclude;
    end
endmodule : csb_channel_tb

// ### dv/csb_peer.sv
`timescale 1ns/100ps
module csb_peer (
    // Link
    input wire logic sck,
    input wire logic sdo,
    output logic sdi,
    // Control and results
    input wire logic en,
    input wire logic take_lvl,
    input wire logic [7:0] reply,
    output logic [7:0] got
);
    logic [7:0] sh = 8'h00;
    logic [2:0] bitn = 3'h0;
    initial got = 8'h00;
    // MSB first; a bit is taken when the clock reaches take_lvl, then the next goes out
    assign sdi = reply[3'h7 - bitn];
    always @(posedge sck or negedge sck or negedge en) begin
        if (!en) begin
            bitn <= 3'h0;
        end else if (sck === take_lvl) begin
            sh <= {sh[6:0], sdo};
            bitn <= bitn + 3'h1;
            if (bitn == 3'h7) begin
                got <= {sh[6:0], sdo};
            end
        end
    end
endmodule : csb_peer
